//--- drt_pkg.sv
// Summary of operation
// (RQ1) Middle timer is an 8-bit down counter with an 8-bit reload latch.
// (RQ2) Latch-only bit set: middle-timer write updates latch only; counter reloads at underflow.
// (RQ3) Latch-only bit clear: middle-timer write loads counter and latch together.
// (RQ4) Reset clears the latch-only write bit.
// (RQ5) Changing middle timer source leaves its reload latch unchanged.
// (RQ6) Software should rewrite a timer after changing its count source.
// (RQ7) Middle timer counts first-timer underflows (select 0) or system clocks (select 1).
// (RQ8) On underflow each timer sets its request, reloads from latch, keeps counting.
// (RQ9) Middle timer drives pulse output when enable and timer-select are both one.
// (RQ10) Middle timer pulse mode: each underflow toggles pin and sets its request.
// (RQ11) Polarity select zero starts output high, one starts it low.
// (RQ12) Third timer is an 8-bit down counter with an 8-bit reload latch.
// (RQ13) Changing third timer source leaves its reload latch unchanged.
// (RQ14) Third timer counts first-timer underflows (select 0) or clock divided by eight.
// (RQ15) Writes to the third timer always load counter and latch.
// (RQ16) Enable set, timer-select clear: first-timer underflows toggle the pulse pin.
// (RQ17) Underflow is a count pulse while counter is zero; reload on that event.
package drt_pkg;
    localparam int DRT_WIDTH = 8;
    localparam int DRT_MODE_WIDTH = 8;
    // Shared mode register field positions
    localparam int DRT_PSEL_BIT = 0;
    localparam int DRT_SRC2_BIT = 3;
    localparam int DRT_SRC3_BIT = 4;
    localparam int DRT_POL_BIT = 5;
    localparam int DRT_PEN_BIT = 6;
    localparam int DRT_LOW_BIT = 7;
    localparam logic [7:0] DRT_MODE_RST = 8'h00;
    localparam logic [7:0] DRT_CNT_RST = 8'hff;
    localparam logic [7:0] DRT_LATCH_RST = 8'hff;
    localparam logic [2:0] DRT_DIV8_RST = 3'h0;
    localparam logic [2:0] DRT_DIV8_LAST = 3'h7;
    localparam logic DRT_POUT_RST = 1'h1;
    localparam logic DRT_IRQ_RST = 1'h0;
endpackage : drt_pkg

//--- drt_timers.sv
`timescale 1ns/1ps
module drt_timers #(
    parameter int WIDTH = drt_pkg::DRT_WIDTH
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [drt_pkg::DRT_MODE_WIDTH-1:0] mode_wdata,
    input wire logic mode_we,
    input wire logic [WIDTH-1:0] timer_wdata,
    input wire logic middle_timer_we,
    input wire logic third_timer_we,
    input wire logic first_timer_underflow,
    output logic [drt_pkg::DRT_MODE_WIDTH-1:0] shared_timer_mode_reg,
    output logic [WIDTH-1:0] middle_timer_count,
    output logic [WIDTH-1:0] middle_timer_latch,
    output logic [WIDTH-1:0] third_timer_count,
    output logic [WIDTH-1:0] third_timer_latch,
    output logic middle_timer_irq_req,
    output logic third_timer_irq_req,
    output logic shared_pulse_output_pin
);
    import drt_pkg::*;

    // ****************************************
    // Parameter checks
    // ****************************************
    // Count and latch fields share the eight-bit write bus, so refuse anything else
    if (WIDTH != DRT_WIDTH)
    begin : g_bad_width
        $error("Timer width must match the write bus");
    end

    typedef struct packed {
        logic [7:0] mode;
        logic [WIDTH-1:0] cnt2;
        logic [WIDTH-1:0] lat2;
        logic [WIDTH-1:0] cnt3;
        logic [WIDTH-1:0] lat3;
        logic [2:0] div8;
        logic irq2;
        logic irq3;
        logic pout;
    } drt_state_t;

    drt_state_t st_q;
    drt_state_t st_d;

    logic latch_only_write_bit;
    logic middle_timer_source_select;
    logic third_timer_source_select;
    logic pulse_output_enable;
    logic pulse_output_timer_select;
    logic pulse_polarity_select;
    logic tick2;
    logic tick3;
    logic uf2;
    logic uf3;
    logic div8_tick;

    assign latch_only_write_bit = st_q.mode[DRT_LOW_BIT];
    assign middle_timer_source_select = st_q.mode[DRT_SRC2_BIT];
    assign third_timer_source_select = st_q.mode[DRT_SRC3_BIT];
    assign pulse_output_enable = st_q.mode[DRT_PEN_BIT];
    assign pulse_output_timer_select = st_q.mode[DRT_PSEL_BIT];
    assign pulse_polarity_select = st_q.mode[DRT_POL_BIT];

    // ****************************************
    // Count sources
    // ****************************************
    assign div8_tick = clk_en && (st_q.div8 == DRT_DIV8_LAST);
    assign tick2 = clk_en && (middle_timer_source_select ? 1'b1 : first_timer_underflow); // [RQ7]
    assign tick3 = clk_en && (third_timer_source_select ? div8_tick
                                                        : first_timer_underflow); // [RQ14]
    assign uf2 = tick2 && (st_q.cnt2 == '0); // [RQ17]
    assign uf3 = tick3 && (st_q.cnt3 == '0); // [RQ17]

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        st_d = st_q;
        st_d.irq2 = 1'b0;
        st_d.irq3 = 1'b0;
        st_d.div8 = st_q.div8 + 3'h1;
        // Source switch touches only the mode bits; latches stay as written
        if (mode_we)
        begin
            st_d.mode = mode_wdata; // [RQ5] [RQ13]
            // Enabling the output presets the starting level
            if (mode_wdata[DRT_PEN_BIT] && !pulse_output_enable)
                st_d.pout = ~mode_wdata[DRT_POL_BIT]; // [RQ11]
        end
        if (!pulse_output_enable)
            st_d.pout = ~(mode_we ? mode_wdata[DRT_POL_BIT] : pulse_polarity_select); // [RQ11]
        // Middle timer
        if (uf2)
        begin
            st_d.cnt2 = st_q.lat2; // [RQ8] [RQ17]
            st_d.irq2 = 1'b1; // [RQ8] [RQ10]
        end
        else if (tick2)
            st_d.cnt2 = st_q.cnt2 - 1'b1; // [RQ1]
        if (middle_timer_we)
        begin
            st_d.lat2 = timer_wdata; // [RQ2] [RQ3]
            if (!latch_only_write_bit)
                st_d.cnt2 = timer_wdata; // [RQ3]
        end
        // Third timer
        if (uf3)
        begin
            st_d.cnt3 = st_q.lat3; // [RQ8]
            st_d.irq3 = 1'b1; // [RQ8]
        end
        else if (tick3)
            st_d.cnt3 = st_q.cnt3 - 1'b1; // [RQ12]
        if (third_timer_we)
        begin
            st_d.lat3 = timer_wdata; // [RQ15]
            st_d.cnt3 = timer_wdata; // [RQ15]
        end
        // Shared pulse pin
        if (pulse_output_enable)
        begin
            if (pulse_output_timer_select ? uf2 : (clk_en && first_timer_underflow))
                st_d.pout = ~st_q.pout; // [RQ9] [RQ10] [RQ16]
        end
        if (!clk_en)
            st_d = st_q;
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            st_q.mode <= DRT_MODE_RST; // [RQ4]
            st_q.cnt2 <= DRT_CNT_RST;
            st_q.lat2 <= DRT_LATCH_RST;
            st_q.cnt3 <= DRT_CNT_RST;
            st_q.lat3 <= DRT_LATCH_RST;
            st_q.div8 <= DRT_DIV8_RST;
            st_q.irq2 <= DRT_IRQ_RST;
            st_q.irq3 <= DRT_IRQ_RST;
            st_q.pout <= DRT_POUT_RST;
        end
        else
            st_q <= st_d;
    end

    assign shared_timer_mode_reg = st_q.mode;
    assign middle_timer_count = st_q.cnt2;
    assign middle_timer_latch = st_q.lat2;
    assign third_timer_count = st_q.cnt3;
    assign third_timer_latch = st_q.lat3;
    assign middle_timer_irq_req = st_q.irq2;
    assign third_timer_irq_req = st_q.irq3;
    assign shared_pulse_output_pin = st_q.pout;

    // ****************************************
    // Checks
    // ****************************************
    a_reset_low_clear: assert property (@(posedge clk_sys) // [RQ4]
        reset |=> !latch_only_write_bit)
        else $error("Latch-only bit not cleared by reset");
    a_direct_write_load: assert property (@(posedge clk_sys) disable iff (reset) // [RQ3]
        clk_en && middle_timer_we && !latch_only_write_bit && !mode_we
        |=> middle_timer_count == $past(timer_wdata) && middle_timer_latch == $past(timer_wdata))
        else $error("Direct write did not load counter and latch");
    a_latch_only_write: assert property (@(posedge clk_sys) disable iff (reset) // [RQ2]
        clk_en && middle_timer_we && latch_only_write_bit && !tick2
        |=> middle_timer_count == $past(st_q.cnt2))
        else $error("Latch-only write changed the counter");
    a_mid_uf_reload: assert property (@(posedge clk_sys) disable iff (reset) // [RQ8]
        uf2 && !middle_timer_we |=> middle_timer_irq_req && middle_timer_count == $past(st_q.lat2))
        else $error("Middle timer underflow did not reload");
    a_third_uf_irq: assert property (@(posedge clk_sys) disable iff (reset) // [RQ8]
        uf3 |=> third_timer_irq_req)
        else $error("Third timer underflow without request");
    a_third_write_both: assert property (@(posedge clk_sys) disable iff (reset) // [RQ15]
        clk_en && third_timer_we
        |=> third_timer_count == $past(timer_wdata) && third_timer_latch == $past(timer_wdata))
        else $error("Third timer write did not load both");
    a_mid_clk_count: assert property (@(posedge clk_sys) disable iff (reset) // [RQ7]
        clk_en && middle_timer_source_select && !mode_we && !middle_timer_we
        && st_q.cnt2 != 8'h00 |=> middle_timer_count == $past(st_q.cnt2) - 8'h01)
        else $error("Middle timer missed a clock count");
    a_pulse_toggle: assert property (@(posedge clk_sys) disable iff (reset) // [RQ10]
        uf2 && pulse_output_enable && pulse_output_timer_select && !mode_we
        |=> shared_pulse_output_pin != $past(shared_pulse_output_pin))
        else $error("Pulse pin did not toggle on underflow");
    a_pulse_first: assert property (@(posedge clk_sys) disable iff (reset) // [RQ16]
        clk_en && first_timer_underflow && pulse_output_enable && !pulse_output_timer_select
        && !mode_we |=> shared_pulse_output_pin != $past(shared_pulse_output_pin))
        else $error("Pulse pin did not follow first timer");
    a_pulse_idle: assert property (@(posedge clk_sys) disable iff (reset) // [RQ11]
        clk_en && !pulse_output_enable && !mode_we
        |=> shared_pulse_output_pin == !$past(pulse_polarity_select))
        else $error("Idle pulse level wrong");
    a_latch_keep: assert property (@(posedge clk_sys) disable iff (reset) // [RQ5] [RQ13]
        mode_we && !middle_timer_we && !third_timer_we
        |=> middle_timer_latch == $past(st_q.lat2) && third_timer_latch == $past(st_q.lat3))
        else $error("Source change disturbed a latch");

    // ****************************************
    // Checks: counting and reload
    // ****************************************
    a_latch_only_latch: assert property (@(posedge clk_sys) disable iff (reset) // [RQ2]
        clk_en && middle_timer_we && latch_only_write_bit
        |=> middle_timer_latch == $past(timer_wdata))
        else $error("Latch-only write missed the latch");

    a_mid_latch_hold: assert property (@(posedge clk_sys) disable iff (reset) // [RQ1]
        clk_en && !middle_timer_we
        |=> middle_timer_latch == $past(middle_timer_latch))
        else $error("Middle latch changed without a write");

    a_mid_first_hold: assert property (@(posedge clk_sys) disable iff (reset) // [RQ7]
        clk_en && !middle_timer_source_select && !first_timer_underflow && !middle_timer_we
        |=> middle_timer_count == $past(middle_timer_count))
        else $error("Middle timer counted without a first-timer underflow");

    a_mid_first_dec: assert property (@(posedge clk_sys) disable iff (reset) // [RQ7]
        clk_en && !middle_timer_source_select && first_timer_underflow && !middle_timer_we
        && st_q.cnt2 != 8'h00 |=> middle_timer_count == $past(st_q.cnt2) - 8'h01)
        else $error("Middle timer missed a first-timer underflow");

    a_mid_clk_uf: assert property (@(posedge clk_sys) disable iff (reset) // [RQ7] [RQ17]
        clk_en && middle_timer_source_select && st_q.cnt2 == 8'h00
        |=> middle_timer_irq_req)
        else $error("Middle timer missed an underflow on the clock");

    a_mid_irq_quiet: assert property (@(posedge clk_sys) disable iff (reset) // [RQ8]
        clk_en && !uf2
        |=> !middle_timer_irq_req)
        else $error("Middle request without an underflow");

    a_third_uf_reload: assert property (@(posedge clk_sys) disable iff (reset) // [RQ8]
        uf3 && !third_timer_we
        |=> third_timer_count == $past(st_q.lat3))
        else $error("Third timer underflow did not reload");

    a_third_first_dec: assert property (@(posedge clk_sys) disable iff (reset) // [RQ14]
        clk_en && !third_timer_source_select && first_timer_underflow && !third_timer_we
        && st_q.cnt3 != 8'h00 |=> third_timer_count == $past(st_q.cnt3) - 8'h01)
        else $error("Third timer missed a first-timer underflow");

    a_third_div_dec: assert property (@(posedge clk_sys) disable iff (reset) // [RQ14]
        div8_tick && third_timer_source_select && !third_timer_we
        && st_q.cnt3 != 8'h00 |=> third_timer_count == $past(st_q.cnt3) - 8'h01)
        else $error("Third timer missed a prescaler tick");

    a_third_div_hold: assert property (@(posedge clk_sys) disable iff (reset) // [RQ14]
        clk_en && third_timer_source_select && !div8_tick && !third_timer_we
        |=> third_timer_count == $past(third_timer_count))
        else $error("Third timer counted between prescaler ticks");

    // Prescaler free-runs from reset, so the first tick after a switch may come early
    a_div8_spacing: assert property (@(posedge clk_sys) disable iff (reset) // [RQ14]
        div8_tick
        |=> (!div8_tick) [*7])
        else $error("Prescaler ticked early");

    a_third_latch_hold: assert property (@(posedge clk_sys) disable iff (reset) // [RQ12]
        clk_en && !third_timer_we
        |=> third_timer_latch == $past(third_timer_latch))
        else $error("Third latch changed without a write");

    a_third_irq_quiet: assert property (@(posedge clk_sys) disable iff (reset) // [RQ8]
        clk_en && !uf3
        |=> !third_timer_irq_req)
        else $error("Third request without an underflow");

    // ****************************************
    // Checks: pulse pin
    // ****************************************
    // Mode writes are left out where a new mode only acts from the next cycle
    a_pulse_hold: assert property (@(posedge clk_sys) disable iff (reset) // [RQ10]
        clk_en && pulse_output_enable && pulse_output_timer_select && !uf2 && !mode_we
        |=> shared_pulse_output_pin == $past(shared_pulse_output_pin))
        else $error("Pulse pin moved between underflows");

    a_pulse_first_hold: assert property (@(posedge clk_sys) disable iff (reset) // [RQ9] [RQ16]
        clk_en && pulse_output_enable && !pulse_output_timer_select && !first_timer_underflow
        && !mode_we |=> shared_pulse_output_pin == $past(shared_pulse_output_pin))
        else $error("Pulse pin moved without a first-timer underflow");

    a_pulse_start: assert property (@(posedge clk_sys) disable iff (reset) // [RQ11]
        clk_en && mode_we && mode_wdata[DRT_PEN_BIT] && !pulse_output_enable
        |=> shared_pulse_output_pin == !$past(mode_wdata[DRT_POL_BIT]))
        else $error("Pulse pin started at the wrong level");

    // ****************************************
    // Checks: mode and enable
    // ****************************************
    a_mode_write: assert property (@(posedge clk_sys) disable iff (reset) // [RQ7] [RQ14]
        clk_en && mode_we
        |=> shared_timer_mode_reg == $past(mode_wdata))
        else $error("Mode write not stored");

    a_state_freeze: assert property (@(posedge clk_sys) disable iff (reset)
        !clk_en
        |=> $stable(st_q))
        else $error("State moved while the enable was low");
endmodule : drt_timers

//--- dual_8bit_reload_timers_tb_top.sv
`timescale 1ns/1ps
module dual_8bit_reload_timers_tb_top;
    import drt_pkg::*;
    // ****************************************
    // Stimulus and checking
    // ****************************************
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic clk_en = 1'b1;
    logic [7:0] wdata = 8'h00;
    logic mode_we = 1'b0;
    logic mid_we = 1'b0;
    logic thr_we = 1'b0;
    logic first_uf = 1'b0;
    logic [7:0] mode, cnt2, lat2, cnt3, lat3;
    logic irq2, irq3, pin;
    int error_cnt = 0;
    int n_compared = 0;
    always #5 clk_sys = ~clk_sys;
    drt_timers DUT (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .mode_wdata(wdata),
        .mode_we(mode_we), .timer_wdata(wdata), .middle_timer_we(mid_we),
        .third_timer_we(thr_we), .first_timer_underflow(first_uf),
        .shared_timer_mode_reg(mode), .middle_timer_count(cnt2), .middle_timer_latch(lat2),
        .third_timer_count(cnt3), .third_timer_latch(lat3), .middle_timer_irq_req(irq2),
        .third_timer_irq_req(irq3), .shared_pulse_output_pin(pin));
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    // Kind 0 mode write, 1 middle write, 2 third write, 3 first-timer underflow
    task automatic put(input logic [7:0] d, input int kind);
        @(negedge clk_sys);
        wdata = d;
        mode_we = (kind == 0);
        mid_we = (kind == 1);
        thr_we = (kind == 2);
        first_uf = (kind == 3);
        @(negedge clk_sys);
        mode_we = 1'b0;
        mid_we = 1'b0;
        thr_we = 1'b0;
        first_uf = 1'b0;
    endtask : put
    task automatic give_verdict;
        $display("compared %0d errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    initial
    begin
        repeat (6) @(negedge clk_sys);
        reset = 1'b0;
        chk("mode", mode, DRT_MODE_RST);
        put(8'h00, 0);
        put(8'h02, 1);
        put(8'h01, 2);
        chk("cnt2", cnt2, 8'h02);
        chk("lat2", lat2, 8'h02);
        chk("lat3", lat3, 8'h01);
        put(8'h00, 3);
        chk("cnt2", cnt2, 8'h01);
        chk("cnt3", cnt3, 8'h00);
        put(8'h00, 3);
        chk("cnt3", cnt3, 8'h01);
        chk("irq3", {7'h00, irq3}, 8'h01);
        chk("irq2", {7'h00, irq2}, 8'h00);
        put(8'h00, 3);
        chk("cnt2", cnt2, 8'h02);
        chk("irq2", {7'h00, irq2}, 8'h01);
        // Frozen while the enable is low, so this tick must be lost
        clk_en = 1'b0;
        put(8'h00, 3);
        clk_en = 1'b1;
        chk("cnt2", cnt2, 8'h02);
        put(8'h80, 0);
        put(8'h05, 1);
        chk("lat2", lat2, 8'h05);
        chk("cnt2", cnt2, 8'h02);
        put(8'h07, 2);
        chk("cnt3", cnt3, 8'h07);
        repeat (3) put(8'h00, 3);
        chk("cnt2", cnt2, 8'h05);
        put(8'h18, 0);
        chk("mode", mode, 8'h18);
        chk("lat2", lat2, 8'h05);
        chk("lat3", lat3, 8'h07);
        // Rewrite after the source switch; small value so a clock-driven reload is seen
        put(8'h02, 1);
        repeat (4) @(negedge clk_sys);
        chk("cnt2", cnt2, 8'h01);
        // Sixteen cycles span two whole prescaler periods whatever its phase
        put(8'h10, 2);
        repeat (16) @(negedge clk_sys);
        chk("cnt3", cnt3, 8'h0e);
        put(8'h41, 0);
        chk("pin", {7'h00, pin}, 8'h01);
        put(8'h00, 1);
        put(8'h00, 3);
        chk("pin", {7'h00, pin}, 8'h00);
        chk("irq2", {7'h00, irq2}, 8'h01);
        put(8'h00, 3);
        chk("pin", {7'h00, pin}, 8'h01);
        put(8'h20, 0);
        put(8'h60, 0);
        chk("pin", {7'h00, pin}, 8'h00);
        put(8'h00, 3);
        chk("pin", {7'h00, pin}, 8'h01);
        // Reset again with the latch-only bit set; writes must go direct afterwards
        put(8'h80, 0);
        reset = 1'b1;
        repeat (2) @(negedge clk_sys);
        reset = 1'b0;
        chk("mode", mode, DRT_MODE_RST);
        put(8'h33, 1);
        chk("cnt2", cnt2, 8'h33);
        chk("lat2", lat2, 8'h33);
        give_verdict();
    end
endmodule : dual_8bit_reload_timers_tb_top
